// File: src/sysctl_pkg.sv
// Constants shared by the system controller: register indices, mode
// bit positions, reset values and the interrupt vector layout.
// Assumes registers are word-indexed; byte address is four times index.
package sysctl_pkg;

  // Register indices
  localparam logic [15:0] IDX_ADC0     = 16'h2000;
  localparam logic [15:0] IDX_ADC3     = 16'h2003;
  localparam logic [15:0] IDX_MODE     = 16'h2015;
  localparam logic [15:0] IDX_STATUS   = 16'h2016;
  localparam logic [15:0] IDX_TS_FLAGS = 16'h2017;
  localparam logic [15:0] IDX_PA_FLAGS = 16'h2019;
  localparam logic [15:0] IDX_PA_INTEN = 16'h201A;

  // Mode control field positions
  localparam int unsigned MC_SP1_UART = 4;
  localparam int unsigned MC_SS_LVL   = 11;
  localparam int unsigned MC_CPHA     = 12;
  localparam int unsigned MC_CPOL     = 13;
  localparam int unsigned MC_SPI_EN   = 14;
  localparam int unsigned MC_SS_GPIO  = 15;

  // Trip/sync flag positions
  localparam int unsigned TS_TRIP = 0;
  localparam int unsigned TS_SYNC = 1;

  // Reset values
  localparam logic [15:0] MODE_RST     = 16'h0000;
  localparam logic [8:0]  PA_INTEN_RST = 9'h000;

  // Vector table
  localparam int unsigned NUM_SRC         = 11;
  localparam logic [5:0]  VT_LAST         = 6'h2F;
  localparam logic [5:0]  VT_ENTRY_WORDS  = 6'h04;
  localparam logic [23:0] VT_FILL_WORD    = 24'h0A_000F;

  // Sources from highest to lowest priority, with their entries
  localparam logic [5:0] VEC_ADDR [NUM_SRC] = '{
    6'h2C, 6'h04, 6'h0C, 6'h08, 6'h18, 6'h1C,
    6'h10, 6'h14, 6'h20, 6'h24, 6'h28
  };

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  typedef enum logic [1:0] {
    BOOT_FILL = 2'b00,
    BOOT_DONE = 2'b01
  } boot_state_t;

endpackage

// File: src/edge_flag.sv
// Sticky edge flags: one bit per line, set on the selected edge.
// Assumes the sampled lines are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module edge_flag #(
  parameter int unsigned WIDTH = 1,
  parameter bit          RISE  = 1'b1,
  parameter bit          FALL  = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] sig_i,
  input  wire logic [WIDTH-1:0] en_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] flags_o
);
  typedef struct packed {
    logic             armed;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] flags;
  } edge_state_t;

  edge_state_t st_reg;
  edge_state_t st_next;

  always_comb begin
    logic [WIDTH-1:0] hit;
    hit = '0;
    st_next = st_reg;
    st_next.armed = 1'b1;
    st_next.prev = sig_i;
    if (st_reg.armed) begin
      hit = ({WIDTH{RISE}} & sig_i & ~st_reg.prev)
          | ({WIDTH{FALL}} & ~sig_i & st_reg.prev);
    end
    // A new edge wins over a clear in the same cycle
    st_next.flags = (st_reg.flags & ~clr_i) | (hit & en_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags_o = st_reg.flags;
endmodule
`default_nettype wire

// File: src/serial_pin_mux.sv
// Routing of both serial ports onto the shared pins.
// Purely combinational; the caller registers the pin values.
`timescale 1ns/1ps
`default_nettype none
module serial_pin_mux (
  input  wire logic sp1_uart_i,
  input  wire logic spi_en_i,
  input  wire logic cpol_i,
  input  wire logic ss_gpio_i,
  input  wire logic ss_lvl_i,
  input  wire logic p0_uart_i,
  input  wire logic primary_serial_clock_i,
  input  wire logic secondary_serial_clock_i,
  input  wire logic secondary_flag_out_i,
  input  wire logic secondary_tx_data_i,
  input  wire logic primary_tx_data_i,
  input  wire logic primary_tx_frame_sync_i,
  input  wire logic tfs_oe_i,
  input  wire logic dr_pin_i,
  input  wire logic rfs_pin_i,
  output logic      shared_clk_o,
  output logic      flag_tx_o,
  output logic      dt0_o,
  output logic      tfs_o,
  output logic      tfs_oe_o,
  output logic      primary_serial_clock_o,
  output logic      rx_data_o,
  output logic      rx_fs_o
);
  always_comb begin
    shared_clk_o = secondary_serial_clock_i;
    flag_tx_o = secondary_flag_out_i;
    if (sp1_uart_i) begin
      shared_clk_o = primary_serial_clock_i;
      flag_tx_o = secondary_tx_data_i;
    end
    dt0_o = primary_tx_data_i;
    rx_data_o = dr_pin_i;
    // UART ties rx data to rx sync
    rx_fs_o = p0_uart_i ? dr_pin_i : rfs_pin_i;
    tfs_o = primary_tx_frame_sync_i;
    tfs_oe_o = tfs_oe_i;
    primary_serial_clock_o = primary_serial_clock_i;
    if (spi_en_i) begin
      rx_fs_o = 1'b0;
      tfs_oe_o = 1'b1;
      tfs_o = ss_gpio_i ? ss_lvl_i : primary_tx_frame_sync_i;
      primary_serial_clock_o = primary_serial_clock_i ^ cpol_i;
    end
  end
endmodule
`default_nettype wire

// File: src/sys_ctrl_irq_and_serial_mux.sv
// System controller: peripheral interrupt flags, shared interrupt
// line, vector selection, serial pin routing and status registers.
// Assumes all inputs are synchronous to core_clk_i; Avalon-MM slave.
//
// Notes on behaviour
// - After reset, fill program RAM words 0x00 to 0x2F with default vectors.
// - Each interrupt source owns four consecutive vector table words.
// - Pending unmasked interrupts reach the sequencer one cycle later, through a register.
// - Timer, serial and software interrupts vector directly, bypassing flags.
// - Trip/sync events set trip/sync flags; I/O events set port A flags.
// - Shared interrupt line stays low while any peripheral flag is pending.
// - Simultaneous pending interrupts: the higher priority vector goes first.
// - Reading trip/sync flags clears the bits it returned and acknowledges.
// - Reading port A flags clears the bits it returned and acknowledges.
// - Status shows trip pin level, watchdog state and PWM timer state.
// - Hardware, software or watchdog reset resets peripherals and registers.
// - Mode bit 4 picks secondary port boot or UART mode.
// - Boot mode: secondary clock and flag out drive the shared pins.
// - Secondary UART: primary clock and secondary tx data on shared pins.
// - Primary UART mode ties internal rx data and rx frame sync together.
// - Mode bit 14 puts the primary port in master-only SPI mode.
// - SPI: tx data is MOSI, rx data MISO, tx sync SS, clock SCK.
// - SPI slave select asserts around each transferred word.
// - Slave select pin may be general I/O without changing transfers.
// - Mode bit 13 sets SPI clock polarity, bit 12 clock phase.
// - Conversion results read left-justified in bits 15..4 at 0x2000-0x2003.
// - Sync flag sets on sync rising edge; trip flag on trip falling edge.
// - Port A interrupt on any level change of an enabled line.
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_irq_and_serial_mux
  import sysctl_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              sw_reset_i,
  input  wire logic              wdog_reset_i,
  input  wire logic [15:0]       address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [3:0]        byteenable_i,
  input  wire logic [31:0]       writedata_i,
  output logic      [31:0]       readdata_o,
  output logic                   waitrequest_o,
  input  wire logic              pwm_sync_pulse_i,
  input  wire logic              pwm_fault_input_i,
  input  wire logic              wdog_expired_i,
  input  wire logic              pwm_timer_phase_i,
  input  wire logic [8:0]        port_a_pins_i,
  input  wire logic [3:0][11:0]  adc_result_i,
  input  wire logic [6:0]        core_irq_req_i,
  output logic                   shared_periph_irq_n_o,
  output logic                   vec_valid_o,
  output logic      [5:0]        vec_addr_o,
  output logic                   vt_we_o,
  output logic      [5:0]        vt_addr_o,
  output logic      [23:0]       vt_data_o,
  output logic                   periph_rst_o,
  input  wire logic              primary_serial_clock_i,
  input  wire logic              secondary_serial_clock_i,
  input  wire logic              secondary_flag_out_i,
  input  wire logic              secondary_tx_data_i,
  input  wire logic              primary_tx_data_i,
  input  wire logic              primary_tx_frame_sync_i,
  input  wire logic              primary_tfs_oe_i,
  input  wire logic              primary_uart_mode_i,
  input  wire logic              dr_pin_i,
  input  wire logic              rfs_pin_i,
  output logic                   shared_clk_pin_o,
  output logic                   flag_tx_pin_o,
  output logic                   dt0_pin_o,
  output logic                   tfs_pin_o,
  output logic                   tfs_pin_oe_o,
  output logic                   primary_serial_clock_pin_o,
  output logic                   primary_rx_data_o,
  output logic                   primary_rx_frame_sync_o,
  output logic                   spi_mode_o,
  output logic                   spi_cpha_o
);
  typedef struct packed {
    bus_state_t  bus;
    logic        waitreq;
    logic [31:0] rdata;
    logic [15:0] mode;
    logic [8:0]  pa_en;
    logic        irq_n;
    logic        vec_valid;
    logic [5:0]  vec_addr;
    boot_state_t boot;
    logic        vt_we;
    logic [5:0]  vt_addr;
    logic        prst;
    logic        shclk;
    logic        fltx;
    logic        dt0;
    logic        tfs;
    logic        tfs_oe;
    logic        primary_serial_clock;
    logic        rxd;
    logic        rxfs;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  logic        any_rst;
  logic        req;
  logic        ack_rd;
  logic [1:0]  ts_flags;
  logic [8:0]  pa_flags;
  logic [1:0]  ts_clr;
  logic [8:0]  pa_clr;
  logic        m_shclk;
  logic        m_fltx;
  logic        m_dt0;
  logic        m_tfs;
  logic        m_tfs_oe;
  logic        m_primary_serial_clock;
  logic        m_rxd;
  logic        m_rxfs;

  // any reset source resets the block
  assign any_rst = rst_i | sw_reset_i | wdog_reset_i;
  assign req = read_i | write_i;
  assign ack_rd = (s_reg.bus == BUS_ACK) && read_i;

  // clear only the bits returned by the read
  assign ts_clr = (ack_rd && address_i == {IDX_TS_FLAGS[13:0], 2'b00})
                  ? s_reg.rdata[1:0] : 2'b00;
  // port A read clears what it returned
  assign pa_clr = (ack_rd && address_i == {IDX_PA_FLAGS[13:0], 2'b00})
                  ? s_reg.rdata[8:0] : 9'h000;

  edge_flag #(.WIDTH(1), .RISE(1'b0), .FALL(1'b1)) u_trip (
    .clk_i   (core_clk_i),
    .rst_i   (any_rst),
    .sig_i   (pwm_fault_input_i),
    .en_i    (1'b1),
    .clr_i   (ts_clr[TS_TRIP]),
    .flags_o (ts_flags[TS_TRIP])
  );

  edge_flag #(.WIDTH(1), .RISE(1'b1), .FALL(1'b0)) u_sync (
    .clk_i   (core_clk_i),
    .rst_i   (any_rst),
    .sig_i   (pwm_sync_pulse_i),
    .en_i    (1'b1),
    .clr_i   (ts_clr[TS_SYNC]),
    .flags_o (ts_flags[TS_SYNC])
  );

  edge_flag #(.WIDTH(9), .RISE(1'b1), .FALL(1'b1)) u_porta (
    .clk_i   (core_clk_i),
    .rst_i   (any_rst),
    .sig_i   (port_a_pins_i),
    .en_i    (s_reg.pa_en),
    .clr_i   (pa_clr),
    .flags_o (pa_flags)
  );

  serial_pin_mux u_mux (
    .sp1_uart_i               (s_reg.mode[MC_SP1_UART]),
    .spi_en_i                 (s_reg.mode[MC_SPI_EN]),
    .cpol_i                   (s_reg.mode[MC_CPOL]),
    .ss_gpio_i                (s_reg.mode[MC_SS_GPIO]),
    .ss_lvl_i                 (s_reg.mode[MC_SS_LVL]),
    .p0_uart_i                (primary_uart_mode_i),
    .primary_serial_clock_i   (primary_serial_clock_i),
    .secondary_serial_clock_i (secondary_serial_clock_i),
    .secondary_flag_out_i     (secondary_flag_out_i),
    .secondary_tx_data_i      (secondary_tx_data_i),
    .primary_tx_data_i        (primary_tx_data_i),
    .primary_tx_frame_sync_i  (primary_tx_frame_sync_i),
    .tfs_oe_i                 (primary_tfs_oe_i),
    .dr_pin_i                 (dr_pin_i),
    .rfs_pin_i                (rfs_pin_i),
    .shared_clk_o             (m_shclk),
    .flag_tx_o                (m_fltx),
    .dt0_o                    (m_dt0),
    .tfs_o                    (m_tfs),
    .tfs_oe_o                 (m_tfs_oe),
    .primary_serial_clock_o                  (m_primary_serial_clock),
    .rx_data_o                (m_rxd),
    .rx_fs_o                  (m_rxfs)
  );

  always_comb begin
    logic [NUM_SRC-1:0] pend;
    logic [31:0]        rd;
    logic [15:0]        idx;
    pend = '0;
    rd = 32'h0000_0000;
    idx = {2'b00, address_i[15:2]};
    s_next = s_reg;

    // Bus: one wait cycle, then the answer with waitrequest low
    s_next.waitreq = 1'b1;
    s_next.bus = BUS_IDLE;
    if (s_reg.bus == BUS_IDLE && req) begin
      if (idx >= IDX_ADC0 && idx <= IDX_ADC3) begin
        rd = {16'h0000, adc_result_i[idx[1:0]], 4'h0};
      end else if (idx == IDX_MODE) begin
        rd = {16'h0000, s_reg.mode};
      end else if (idx == IDX_STATUS) begin
        rd = {29'h0000_0000, pwm_timer_phase_i, wdog_expired_i,
              pwm_fault_input_i};
      end else if (idx == IDX_TS_FLAGS) begin
        rd = {30'h0000_0000, ts_flags};
      end else if (idx == IDX_PA_FLAGS) begin
        rd = {23'h00_0000, pa_flags};
      end else if (idx == IDX_PA_INTEN) begin
        rd = {23'h00_0000, s_reg.pa_en};
      end
      s_next.rdata = read_i ? rd : 32'h0000_0000;
      s_next.bus = BUS_ACK;
      s_next.waitreq = 1'b0;
    end

    if (s_reg.bus == BUS_ACK && write_i) begin
      if (idx == IDX_MODE) begin
        if (byteenable_i[0]) begin
          s_next.mode[7:0] = writedata_i[7:0];
        end
        if (byteenable_i[1]) begin
          s_next.mode[15:8] = writedata_i[15:8];
        end
      end else if (idx == IDX_PA_INTEN) begin
        if (byteenable_i[0]) begin
          s_next.pa_en[7:0] = writedata_i[7:0];
        end
        if (byteenable_i[1]) begin
          s_next.pa_en[8] = writedata_i[8];
        end
      end
    end

    s_next.irq_n = ~(|ts_flags | |pa_flags);

    pend = {core_irq_req_i[6], core_irq_req_i[5], core_irq_req_i[4],
            core_irq_req_i[3], core_irq_req_i[2], core_irq_req_i[1],
            core_irq_req_i[0], |pa_flags, ts_flags[TS_SYNC],
            |ts_flags | |pa_flags, ts_flags[TS_TRIP]};
    s_next.vec_valid = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        s_next.vec_addr = VEC_ADDR[i];
        s_next.vec_valid = (s_reg.boot == BOOT_DONE);
      end
    end

    case (s_reg.boot)
      BOOT_FILL: begin
        s_next.vt_we = 1'b1;
        if (s_reg.vt_we) begin
          s_next.vt_addr = s_reg.vt_addr + 6'h01;
          if (s_reg.vt_addr == VT_LAST) begin
            s_next.vt_we = 1'b0;
            s_next.vt_addr = s_reg.vt_addr;
            s_next.boot = BOOT_DONE;
          end
        end
      end
      BOOT_DONE: begin
        s_next.vt_we = 1'b0;
      end
      default: begin
        s_next.boot = BOOT_DONE;
      end
    endcase

    s_next.prst = any_rst;

    // Serial pin routing from the mode bits, registered
    s_next.shclk = m_shclk;
    s_next.fltx = m_fltx;
    s_next.dt0 = m_dt0;
    s_next.tfs = m_tfs;
    s_next.tfs_oe = m_tfs_oe;
    s_next.primary_serial_clock = m_primary_serial_clock;
    s_next.rxd = m_rxd;
    s_next.rxfs = m_rxfs;
  end

  always_ff @(posedge core_clk_i) begin
    if (any_rst) begin
      s_reg <= '0;
      s_reg.bus <= BUS_IDLE;
      s_reg.boot <= BOOT_FILL;
      s_reg.waitreq <= 1'b1;
      s_reg.mode <= MODE_RST;
      s_reg.pa_en <= PA_INTEN_RST;
      s_reg.irq_n <= 1'b1;
      s_reg.prst <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata_o = s_reg.rdata;
  assign waitrequest_o = s_reg.waitreq;
  assign shared_periph_irq_n_o = s_reg.irq_n;
  assign vec_valid_o = s_reg.vec_valid;
  assign vec_addr_o = s_reg.vec_addr;
  assign vt_we_o = s_reg.vt_we;
  assign vt_addr_o = s_reg.vt_addr;
  assign vt_data_o = VT_FILL_WORD;
  assign periph_rst_o = s_reg.prst;
  assign shared_clk_pin_o = s_reg.shclk;
  assign flag_tx_pin_o = s_reg.fltx;
  assign dt0_pin_o = s_reg.dt0;
  assign tfs_pin_o = s_reg.tfs;
  assign tfs_pin_oe_o = s_reg.tfs_oe;
  assign primary_serial_clock_pin_o = s_reg.primary_serial_clock;
  assign primary_rx_data_o = s_reg.rxd;
  assign primary_rx_frame_sync_o = s_reg.rxfs;
  assign spi_mode_o = s_reg.mode[MC_SPI_EN];
  assign spi_cpha_o = s_reg.mode[MC_CPHA];

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (any_rst);

  irq_pending_low_a : assert property (
    (|ts_flags || |pa_flags) |=> !shared_periph_irq_n_o
  ) else $error("shared line not low while flags pend");

  irq_release_a : assert property (
    (ts_flags == 2'b00 && pa_flags == 9'h000) |=> shared_periph_irq_n_o
  ) else $error("shared line not released after flags empty");

  trip_flag_set_a : assert property (
    $fell(pwm_fault_input_i) |=> ts_flags[TS_TRIP]
  ) else $error("trip fall did not set flag");

  sync_flag_set_a : assert property (
    $rose(pwm_sync_pulse_i) |=> ts_flags[TS_SYNC]
  ) else $error("sync rise did not set flag");

  pio_flag_set_a : assert property (
    ($changed(port_a_pins_i[0]) && $past(s_reg.pa_en[0]) && s_reg.pa_en[0])
    |=> pa_flags[0]
  ) else $error("enabled line change did not set flag");

  ts_read_clear_a : assert property (
    (ts_clr == ts_flags && ts_flags != 2'b00 && !$rose(pwm_sync_pulse_i)
     && !$fell(pwm_fault_input_i)) |=> ts_flags == 2'b00
  ) else $error("trip/sync read did not clear");

  pa_read_clear_a : assert property (
    (pa_clr == pa_flags && pa_flags != 9'h000 && $stable(port_a_pins_i))
    |=> pa_flags == 9'h000
  ) else $error("port A read did not clear");

  boot_route_a : assert property (
    (!s_reg.mode[MC_SP1_UART]) |=> (shared_clk_pin_o ==
      $past(secondary_serial_clock_i) && flag_tx_pin_o ==
      $past(secondary_flag_out_i))
  ) else $error("boot mode pin routing wrong");

  uart_route_a : assert property (
    s_reg.mode[MC_SP1_UART] |=> (shared_clk_pin_o ==
      $past(primary_serial_clock_i) && flag_tx_pin_o ==
      $past(secondary_tx_data_i))
  ) else $error("secondary UART pin routing wrong");

  spi_pins_a : assert property (
    s_reg.mode[MC_SPI_EN] |=> (dt0_pin_o == $past(primary_tx_data_i)
      && tfs_pin_oe_o && !primary_rx_frame_sync_o)
  ) else $error("SPI pin roles wrong");

  spi_clock_pol_a : assert property (
    s_reg.mode[MC_SPI_EN] |=> primary_serial_clock_pin_o ==
      ($past(primary_serial_clock_i) ^ $past(s_reg.mode[MC_CPOL]))
  ) else $error("SPI clock polarity wrong");

  trip_priority_a : assert property (
    (ts_flags[TS_TRIP] && s_reg.boot == BOOT_DONE)
    |=> (vec_valid_o && vec_addr_o == 6'h2C)
  ) else $error("trip vector not chosen first");

  vt_range_a : assert property (
    vt_we_o |-> vt_addr_o <= 6'h2F
  ) else $error("vector fill out of range");

endmodule
`default_nettype wire

// File: bench/core_model.sv
// Core side model: collects the vector table fill, counts shared
// interrupts taken. Assumes the same clock as the block; reset by hardware or watchdog reset only.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import sysctl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        irq_n_i,
  input  wire logic        vt_we_i,
  input  wire logic [5:0]  vt_addr_i,
  input  wire logic [23:0] vt_data_i,
  input  wire logic [15:0] core_irq_mask_i,
  output var  int          fill_cnt_o,
  output var  logic        fill_bad_o,
  output var  int          irq_taken_o
);
  logic irq_n_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_cnt_o  <= 0;
      fill_bad_o  <= 1'b0;
      irq_taken_o <= 0;
      irq_n_reg   <= 1'b1;
    end else begin
      irq_n_reg <= irq_n_i;
      if (vt_we_i) begin
        fill_cnt_o <= fill_cnt_o + 1;
        if (vt_addr_i > VT_LAST || vt_data_i !== VT_FILL_WORD)
          fill_bad_o <= 1'b1;
      end
      if (core_irq_mask_i[9] && irq_n_reg && !irq_n_i)
        irq_taken_o <= irq_taken_o + 1;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Directed bench for the system controller over Avalon-MM.
// Assumes core_model watches the interrupt and vector fill side.
`timescale 1ns/1ps
`default_nettype none
module tb
  import sysctl_pkg::*;
;
  logic        core_clk_i, rst_i, sw_reset_i, wdog_reset_i, read_i, write_i;
  logic        pwm_sync_pulse_i, pwm_fault_input_i, wdog_expired_i, pwm_timer_phase_i;
  logic        primary_serial_clock_i, secondary_serial_clock_i, secondary_flag_out_i;
  logic        secondary_tx_data_i, primary_tx_data_i, primary_tx_frame_sync_i;
  logic        primary_tfs_oe_i, primary_uart_mode_i, dr_pin_i, rfs_pin_i;
  logic [15:0] address_i, mask;
  logic [3:0]  byteenable_i;
  logic [31:0] writedata_i, readdata_o;
  logic [8:0]  port_a_pins_i;
  logic [3:0][11:0] adc_result_i;
  logic [6:0]  core_irq_req_i;
  logic [5:0]  vec_addr_o, vt_addr_o;
  logic [23:0] vt_data_o;
  logic        waitrequest_o, shared_periph_irq_n_o, vec_valid_o, vt_we_o, periph_rst_o;
  logic        shared_clk_pin_o, flag_tx_pin_o, dt0_pin_o, tfs_pin_o, tfs_pin_oe_o;
  logic        primary_serial_clock_pin_o, primary_rx_data_o, primary_rx_frame_sync_o, spi_mode_o, spi_cpha_o;
  logic        fill_bad;
  logic [15:0] q;
  int          fill_cnt, irq_taken, err_total, samples_checked;

  sys_ctrl_irq_and_serial_mux dut_u (
    .core_clk_i, .rst_i, .sw_reset_i, .wdog_reset_i, .address_i, .read_i, .write_i,
    .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .pwm_sync_pulse_i,
    .pwm_fault_input_i, .wdog_expired_i, .pwm_timer_phase_i, .port_a_pins_i,
    .adc_result_i, .core_irq_req_i, .shared_periph_irq_n_o, .vec_valid_o, .vec_addr_o,
    .vt_we_o, .vt_addr_o, .vt_data_o, .periph_rst_o, .primary_serial_clock_i,
    .secondary_serial_clock_i, .secondary_flag_out_i, .secondary_tx_data_i,
    .primary_tx_data_i, .primary_tx_frame_sync_i, .primary_tfs_oe_i, .primary_uart_mode_i,
    .dr_pin_i, .rfs_pin_i, .shared_clk_pin_o, .flag_tx_pin_o, .dt0_pin_o, .tfs_pin_o,
    .tfs_pin_oe_o, .primary_serial_clock_pin_o, .primary_rx_data_o, .primary_rx_frame_sync_o,
    .spi_mode_o, .spi_cpha_o);

  core_model core_u (
    .clk_i(core_clk_i), .rst_i(rst_i | wdog_reset_i), .irq_n_i(shared_periph_irq_n_o),
    .vt_we_i(vt_we_o), .vt_addr_i(vt_addr_o), .vt_data_i(vt_data_o),
    .core_irq_mask_i(mask), .fill_cnt_o(fill_cnt), .fill_bad_o(fill_bad),
    .irq_taken_o(irq_taken));

  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d);
    int n;
    @(posedge core_clk_i);
    address_i   <= {idx[13:0], 2'b00};
    write_i     <= w;
    read_i      <= ~w;
    writedata_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 64);
    if (waitrequest_o !== 1'b0) begin
      err_total++;
      print_verdict();
    end else begin
      q = readdata_o[15:0];
      read_i  <= 1'b0;
      write_i <= 1'b0;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(q, exp);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial begin
    #20000;
    err_total++;
    print_verdict();
  end

  initial begin
    {rst_i, sw_reset_i, wdog_reset_i, read_i, write_i} = 5'b10000;
    {pwm_sync_pulse_i, pwm_fault_input_i, wdog_expired_i, pwm_timer_phase_i} = 4'b0100;
    {primary_serial_clock_i, secondary_serial_clock_i, secondary_flag_out_i} = 3'b011;
    {secondary_tx_data_i, primary_tx_data_i, primary_tx_frame_sync_i} = 3'b011;
    {primary_tfs_oe_i, primary_uart_mode_i, dr_pin_i, rfs_pin_i} = 4'b1010;
    {address_i, byteenable_i, writedata_i, port_a_pins_i} = '0;
    byteenable_i = 4'hF;
    adc_result_i = {12'h123, 12'h000, 12'h000, 12'hABC};
    {core_irq_req_i, err_total, samples_checked} = '0;
    mask = 16'h0200;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_n(60);
    chk(fill_cnt[15:0], {10'h000, VT_LAST} + 16'h0001);
    chk({15'h0000, fill_bad}, 16'h0000);
    chk({15'h0000, periph_rst_o}, 16'h0000);
    rd_chk(IDX_MODE, MODE_RST);
    rd_chk(16'h2014, 16'h0000);
    rd_chk(IDX_ADC0, 16'hABC0);
    rd_chk(IDX_ADC3, 16'h1230);
    chk({14'h0000, shared_clk_pin_o, flag_tx_pin_o}, 16'h0003);
    $display("test reset and boot pins done");
    @(posedge core_clk_i) pwm_fault_input_i <= 1'b0;
    wait_n(4);
    chk({15'h0000, shared_periph_irq_n_o}, 16'h0000);
    @(posedge core_clk_i) pwm_sync_pulse_i <= 1'b1;
    @(posedge core_clk_i) pwm_sync_pulse_i <= 1'b0;
    wait_n(3);
    chk({10'h000, vec_addr_o}, {10'h000, VEC_ADDR[0]});
    rd_chk(IDX_TS_FLAGS, 16'h0003);
    wait_n(2);
    chk({15'h0000, shared_periph_irq_n_o}, 16'h0001);
    @(posedge core_clk_i) {wdog_expired_i, pwm_timer_phase_i} <= 2'b11;
    rd_chk(IDX_STATUS, 16'h0006);
    {pwm_fault_input_i, wdog_expired_i} <= 2'b10;
    rd_chk(IDX_STATUS, 16'h0005);
    rd_chk(IDX_TS_FLAGS, 16'h0000);
    $display("test trip and sync done");
    bus(1'b1, IDX_PA_INTEN, 16'h01FF);
    port_a_pins_i <= 9'h008;
    wait_n(4);
    chk({15'h0000, shared_periph_irq_n_o}, 16'h0000);
    rd_chk(IDX_PA_FLAGS, 16'h0008);
    port_a_pins_i <= 9'h000;
    rd_chk(IDX_PA_FLAGS, 16'h0008);
    rd_chk(IDX_PA_FLAGS, 16'h0000);
    bus(1'b1, IDX_PA_INTEN, 16'h0001);
    port_a_pins_i <= 9'h008;
    rd_chk(IDX_PA_FLAGS, 16'h0000);
    $display("test port a done");
    core_irq_req_i <= 7'h41;
    wait_n(3);
    chk({9'h000, vec_valid_o, vec_addr_o}, {10'h001, VEC_ADDR[4]});
    chk({15'h0000, shared_periph_irq_n_o}, 16'h0001);
    @(posedge core_clk_i) core_irq_req_i <= 7'h40;
    wait_n(3);
    chk({10'h000, vec_addr_o}, {10'h000, VEC_ADDR[10]});
    @(posedge core_clk_i) core_irq_req_i <= 7'h00;
    bus(1'b1, IDX_MODE, 16'h0010);
    wait_n(3);
    chk({14'h0000, shared_clk_pin_o, flag_tx_pin_o}, 16'h0000);
    bus(1'b1, IDX_MODE, 16'h7000);
    wait_n(3);
    chk({8'h00, spi_mode_o, spi_cpha_o, dt0_pin_o, tfs_pin_o, primary_rx_data_o,
         primary_serial_clock_pin_o, tfs_pin_oe_o, primary_rx_frame_sync_o},
        16'h00FE);
    rd_chk(IDX_MODE, 16'h7000);
    bus(1'b1, IDX_MODE, 16'hC000);
    wait_n(3);
    chk({15'h0000, tfs_pin_o}, 16'h0000);
    chk(irq_taken[15:0], 16'h0003);
    $display("test routing done");
    @(posedge core_clk_i) wdog_reset_i <= 1'b1;
    @(posedge core_clk_i) wdog_reset_i <= 1'b0;
    rd_chk(IDX_MODE, MODE_RST);
    rd_chk(IDX_PA_INTEN, {7'h00, PA_INTEN_RST});
    @(posedge core_clk_i) primary_uart_mode_i <= 1'b1;
    wait_n(3);
    chk({15'h0000, primary_rx_frame_sync_o}, 16'h0001);
    $display("test watchdog reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
